// *** inc/ppcr_params.svh ***
/*
  Register map, field positions, reset values and timing counts of the
  playback path control registers.
  Assumes a 250 MHz system clock; included by bare name.
*/
`ifndef PPCR_PARAMS_SVH
`define PPCR_PARAMS_SVH

`define PPCR_ADDR_CONV_L      8'h69
`define PPCR_ADDR_CONV_R      8'h6a
`define PPCR_ADDR_PHONES_L    8'h6b
`define PPCR_ADDR_PHONES_R    8'h6c
`define PPCR_ADDR_MIXER_L     8'h6e
`define PPCR_ADDR_MIXER_R     8'h6f
`define PPCR_ADDR_PAD         8'h91

`define PPCR_BIT_ENABLE       7
`define PPCR_BIT_MUTE         6
`define PPCR_BIT_RAMP         5
`define PPCR_BIT_ZERO_CROSS   4
`define PPCR_BIT_DRIVE        3
`define PPCR_BIT_FLOOR        2
`define PPCR_BIT_LOW_RANGE    0

`define PPCR_MASK_CONV        8'he0
`define PPCR_MASK_PHONES      8'hfc
`define PPCR_MASK_MIXER       8'h80
`define PPCR_MASK_PAD         8'h01

`define PPCR_RST_CONV         8'h40
`define PPCR_RST_PHONES       8'h40
`define PPCR_RST_MIXER        8'h00
`define PPCR_RST_PAD          8'h00

`define PPCR_CLK_MHZ          250
`define PPCR_ZC_TIMEOUT_MS    100
`define PPCR_ZC_TIMEOUT_CYC   (`PPCR_ZC_TIMEOUT_MS * 1000 * `PPCR_CLK_MHZ)

`endif

// *** inc/ppcr_pkg.sv ***
/*
  Types shared by the playback path control register bank.
  Assumes ppcr_params.svh is on the include path.
*/
package ppcr_pkg;
  typedef logic [7:0] ppcr_byte_t;
  typedef enum logic {PPCR_LEFT, PPCR_RIGHT} ppcr_chan_t;
endpackage

// *** src/ppcr_gain_update.sv ***
/*
  Applies a requested gain to one channel: instantly, ramped one step per
  tick, or at a zero crossing with a timeout fallback; optional floor hold.
  Assumes target, tick and crossing strobes are synchronous to clk.
*/
`timescale 1ns/1ps
module ppcr_gain_update
  import ppcr_pkg::*;
#(
  parameter int GW      = 6,
  parameter int TIMEOUT = 25000000
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // settings
  input  wire logic          ramp,
  input  wire logic          zero_cross,
  input  wire logic          floor_hold,
  // events and target
  input  wire logic          ramp_tick,
  input  wire logic          zero_det,
  input  wire logic [GW-1:0] target,
  // applied gain
  output logic      [GW-1:0] gain_ff
);
  localparam int TW = $clog2(TIMEOUT + 1);
  localparam logic [TW-1:0] TLAST = TW'(TIMEOUT - 1);

  logic [TW-1:0] timer_ff;
  logic          pending;
  logic          timed_out;

  // ramping wins over zero-cross waiting
  assign pending   = !floor_hold && !ramp && zero_cross && (target != gain_ff); // [RQ6] [RQ7]
  assign timed_out = (timer_ff == TLAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff <= '0;
    end else if (pending && !zero_det && !timed_out) begin
      timer_ff <= timer_ff + TW'(1);
    end else begin
      timer_ff <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_ff <= '0;
    end else if (floor_hold) begin
      gain_ff <= '0; // [RQ10]
    end else if (target != gain_ff) begin
      if (ramp) begin
        if (ramp_tick) begin // [RQ3] [RQ6]
          gain_ff <= (target > gain_ff) ? gain_ff + GW'(1) : gain_ff - GW'(1);
        end
      end else if (zero_cross) begin
        if (zero_det || timed_out) begin // [RQ7] [RQ8]
          gain_ff <= target;
        end
      end else begin
        gain_ff <= target;
      end
    end
  end
endmodule

// *** src/ppcr_regs.sv ***
/*
  Control register bank for the stereo playback path: converter, headphone
  amplifier and output mixer controls plus the pad voltage range select.
  Assumes the control interface delivers single-cycle read and write strobes
  with address and data synchronous to clk; gain targets, mixer selects,
  ramp ticks and zero-crossing strobes come from neighbouring blocks.
*/
// How it works
// RQ1 - converter bit 7 enables path, resets off
// RQ2 - converter bit 6 mutes, resets muted
// RQ3 - converter bit 5 ramps gain, else instant
// RQ4 - amplifier bit 7 enables amplifier, resets off
// RQ5 - amplifier bit 6 mutes, resets muted
// RQ6 - amplifier bit 5 ramps, overrides zero cross
// RQ7 - amplifier bit 4 applies gain at zero
// RQ8 - zero-cross wait times out after 100 ms
// RQ9 - amplifier bit 3 drives output, else hi-Z
// RQ10 - amplifier bit 2 holds minimum gain
// RQ11 - mixer bit 7 enables mixer, resets off
// RQ12 - pad bit 0 set selects low range
// RQ13 - mixer passes converter only when selected
// RQ14 - undefined bits read zero, ignore writes
`timescale 1ns/1ps
`include "ppcr_params.svh"
module ppcr_regs
  import ppcr_pkg::*;
#(
  parameter int CGW             = 8,
  parameter int PGW             = 6,
  parameter int ZC_TIMEOUT_CYCLES = `PPCR_ZC_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // register access port
  input  wire logic                  reg_wr_en,
  input  wire logic                  reg_rd_en,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata_ff,
  // gain sources and events
  input  wire logic [1:0][CGW-1:0]   conv_gain_target,
  input  wire logic [1:0][PGW-1:0]   phones_gain_target,
  input  wire logic                  gain_ramp_tick,
  input  wire logic [1:0]            phones_zero_det,
  input  wire logic [1:0]            mixer_select,
  // converter controls
  output logic      [1:0]            conv_enable,
  output logic      [1:0]            conv_mute,
  output logic      [1:0][CGW-1:0]   conv_gain_ff,
  // headphone amplifier controls
  output logic      [1:0]            phones_enable,
  output logic      [1:0]            phones_mute,
  output logic      [1:0]            phones_drive,
  output logic      [1:0][PGW-1:0]   phones_gain_ff,
  // output mixer and pads
  output logic      [1:0]            mixer_enable,
  output logic      [1:0]            mixer_pass_ff,
  output logic                       pad_low_range
);
  ppcr_byte_t conv_ctrl_ff   [2];
  ppcr_byte_t phones_ctrl_ff [2];
  ppcr_byte_t mixer_ctrl_ff  [2];
  ppcr_byte_t pad_ctrl_ff;
  ppcr_byte_t nxt_rdata;

  // picks the left or right address of a register pair
  function automatic logic [7:0] pick(input ppcr_chan_t ch, input logic [7:0] l,
                                      input logic [7:0] r);
    return (ch == PPCR_RIGHT) ? r : l;
  endfunction

  function automatic logic hit(input logic [7:0] a);
    return reg_wr_en && (reg_addr == a);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_ctrl_ff[0] <= `PPCR_RST_CONV; // [RQ1] [RQ2] [RQ3]
      conv_ctrl_ff[1] <= `PPCR_RST_CONV;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (hit(pick(ppcr_chan_t'(c), `PPCR_ADDR_CONV_L, `PPCR_ADDR_CONV_R))) begin
          conv_ctrl_ff[c] <= reg_wdata & `PPCR_MASK_CONV; // [RQ14]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phones_ctrl_ff[0] <= `PPCR_RST_PHONES; // [RQ4] [RQ5] [RQ9]
      phones_ctrl_ff[1] <= `PPCR_RST_PHONES;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (hit(pick(ppcr_chan_t'(c), `PPCR_ADDR_PHONES_L, `PPCR_ADDR_PHONES_R))) begin
          phones_ctrl_ff[c] <= reg_wdata & `PPCR_MASK_PHONES; // [RQ14]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mixer_ctrl_ff[0] <= `PPCR_RST_MIXER; // [RQ11]
      mixer_ctrl_ff[1] <= `PPCR_RST_MIXER;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (hit(pick(ppcr_chan_t'(c), `PPCR_ADDR_MIXER_L, `PPCR_ADDR_MIXER_R))) begin
          mixer_ctrl_ff[c] <= reg_wdata & `PPCR_MASK_MIXER; // [RQ14]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_ctrl_ff <= `PPCR_RST_PAD;
    end else if (hit(`PPCR_ADDR_PAD)) begin
      pad_ctrl_ff <= reg_wdata & `PPCR_MASK_PAD; // [RQ12] [RQ14]
    end
  end

  // unmapped addresses and reserved bits read as zero
  always_comb begin
    unique case (reg_addr)
      `PPCR_ADDR_CONV_L:   nxt_rdata = conv_ctrl_ff[0];
      `PPCR_ADDR_CONV_R:   nxt_rdata = conv_ctrl_ff[1];
      `PPCR_ADDR_PHONES_L: nxt_rdata = phones_ctrl_ff[0];
      `PPCR_ADDR_PHONES_R: nxt_rdata = phones_ctrl_ff[1];
      `PPCR_ADDR_MIXER_L:  nxt_rdata = mixer_ctrl_ff[0];
      `PPCR_ADDR_MIXER_R:  nxt_rdata = mixer_ctrl_ff[1];
      `PPCR_ADDR_PAD:      nxt_rdata = pad_ctrl_ff;
      default:             nxt_rdata = 8'h00; // [RQ14]
    endcase
  end

  // read data holds until the next read so a slow interface can sample it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // mixer output is gated by its own enable so a stale select cannot leak
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mixer_pass_ff <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        mixer_pass_ff[c] <= mixer_ctrl_ff[c][`PPCR_BIT_ENABLE] && mixer_select[c]; // [RQ13]
      end
    end
  end

  assign pad_low_range = pad_ctrl_ff[`PPCR_BIT_LOW_RANGE]; // [RQ12]

  for (genvar c = 0; c < 2; c++) begin : g_chan
    assign conv_enable[c]   = conv_ctrl_ff[c][`PPCR_BIT_ENABLE]; // [RQ1]
    assign conv_mute[c]     = conv_ctrl_ff[c][`PPCR_BIT_MUTE]; // [RQ2]
    assign phones_enable[c] = phones_ctrl_ff[c][`PPCR_BIT_ENABLE]; // [RQ4]
    assign phones_mute[c]   = phones_ctrl_ff[c][`PPCR_BIT_MUTE]; // [RQ5]
    assign phones_drive[c]  = phones_ctrl_ff[c][`PPCR_BIT_DRIVE]; // [RQ9]
    assign mixer_enable[c]  = mixer_ctrl_ff[c][`PPCR_BIT_ENABLE]; // [RQ11]

    // converter gain never waits for a crossing and has no floor
    ppcr_gain_update #(
      .GW      (CGW),
      .TIMEOUT (ZC_TIMEOUT_CYCLES)
    ) u_conv_gain (
      .clk        (clk),
      .rst_n      (rst_n),
      .ramp       (conv_ctrl_ff[c][`PPCR_BIT_RAMP]), // [RQ3]
      .zero_cross (1'b0),
      .floor_hold (1'b0),
      .ramp_tick  (gain_ramp_tick),
      .zero_det   (1'b0),
      .target     (conv_gain_target[c]),
      .gain_ff    (conv_gain_ff[c])
    );

    ppcr_gain_update #(
      .GW      (PGW),
      .TIMEOUT (ZC_TIMEOUT_CYCLES)
    ) u_phones_gain (
      .clk        (clk),
      .rst_n      (rst_n),
      .ramp       (phones_ctrl_ff[c][`PPCR_BIT_RAMP]), // [RQ6]
      .zero_cross (phones_ctrl_ff[c][`PPCR_BIT_ZERO_CROSS]), // [RQ7] [RQ8]
      .floor_hold (phones_ctrl_ff[c][`PPCR_BIT_FLOOR]), // [RQ10]
      .ramp_tick  (gain_ramp_tick),
      .zero_det   (phones_zero_det[c]),
      .target     (phones_gain_target[c]),
      .gain_ff    (phones_gain_ff[c])
    );
  end
endmodule

// *** bench/ppcr_regs_props.sv ***
/*
  Port checker for the playback control register bank.
  Bound onto ppcr_regs; sees only its ports; one clock domain.
*/
`timescale 1ns/1ps
module ppcr_regs_props #(
  parameter int CGW               = 8,
  parameter int PGW               = 6,
  parameter int ZC_TIMEOUT_CYCLES = 16
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // register access
  input wire logic                reg_wr_en,
  input wire logic                reg_rd_en,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata_ff,
  // controls
  input wire logic [1:0]          mixer_select,
  input wire logic [1:0]          conv_enable,
  input wire logic [1:0]          conv_mute,
  input wire logic [1:0]          phones_enable,
  input wire logic [1:0]          phones_mute,
  input wire logic [1:0]          phones_drive,
  input wire logic [1:0][PGW-1:0] phones_gain_ff,
  input wire logic [1:0]          mixer_enable,
  input wire logic [1:0]          mixer_pass_ff,
  input wire logic                pad_low_range
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_conv_left_enable: assert property (reg_wr_en && reg_addr == 8'h69 |=>
    conv_enable[0] == $past(reg_wdata[7])) else $error("converter enable wrong");
  a_conv_right_mute: assert property (reg_wr_en && reg_addr == 8'h6a |=>
    conv_mute[1] == $past(reg_wdata[6])) else $error("converter mute wrong");
  a_phones_left_fields: assert property (reg_wr_en && reg_addr == 8'h6b |=>
    {phones_enable[0], phones_mute[0], phones_drive[0]} ==
    {$past(reg_wdata[7:6]), $past(reg_wdata[3])}) else $error("amplifier fields wrong");
  a_floor_gain_hold: assert property (reg_wr_en && reg_addr == 8'h6b && reg_wdata[2] |->
    ##2 phones_gain_ff[0] == '0) else $error("floor gain not applied");
  a_mixer_right_enable: assert property (reg_wr_en && reg_addr == 8'h6f |=>
    mixer_enable[1] == $past(reg_wdata[7])) else $error("mixer enable wrong");
  a_pad_range_select: assert property (reg_wr_en && reg_addr == 8'h91 |=>
    pad_low_range == $past(reg_wdata[0])) else $error("pad range wrong");
  a_mixer_pass_gate: assert property (
    mixer_pass_ff == $past(mixer_enable & mixer_select)) else $error("mixer pass wrong");
  a_mixer_read_zero: assert property (reg_rd_en && reg_addr[7:1] == 7'h37 |=>
    reg_rdata_ff[6:0] == 7'h00) else $error("mixer reserved bits read set");
  a_unmapped_read_zero: assert property (reg_rd_en && !(reg_addr inside
    {8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6e, 8'h6f, 8'h91}) |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind ppcr_regs ppcr_regs_props #(.CGW(CGW), .PGW(PGW), .ZC_TIMEOUT_CYCLES(ZC_TIMEOUT_CYCLES))
  ppcr_regs_props_inst (.clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
  .reg_rdata_ff, .mixer_select, .conv_enable, .conv_mute, .phones_enable, .phones_mute,
  .phones_drive, .phones_gain_ff, .mixer_enable, .mixer_pass_ff, .pad_low_range);

// *** bench/tb.sv ***
/*
  Self-checking bench for ppcr_regs through its register strobes.
  Assumes ppcr_pkg compiled first; zero-cross timeout shortened to 16 cycles.
*/
`timescale 1ns/1ps
module tb;
  import ppcr_pkg::*;
  localparam int ZC = 16;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            reg_wr_en = 1'b0;
  logic            reg_rd_en = 1'b0;
  ppcr_byte_t      reg_addr = 8'h00;
  ppcr_byte_t      reg_wdata = 8'h00;
  ppcr_byte_t      reg_rdata_ff;
  logic [1:0][7:0] conv_gain_target = '0;
  logic [1:0][5:0] phones_gain_target = '0;
  logic            gain_ramp_tick = 1'b0;
  logic [1:0]      phones_zero_det = 2'b00;
  logic [1:0]      mixer_select = 2'b00;
  logic [1:0]      conv_enable, conv_mute, phones_enable, phones_mute, phones_drive;
  logic [1:0]      mixer_enable, mixer_pass_ff;
  logic [1:0][7:0] conv_gain_ff;
  logic [1:0][5:0] phones_gain_ff;
  logic            pad_low_range;
  int              mismatches = 0;
  int              checked = 0;
  ppcr_byte_t      addrs [7] = '{8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6e, 8'h6f, 8'h91};
  ppcr_byte_t      masks [7] = '{8'he0, 8'he0, 8'hfc, 8'hfc, 8'h80, 8'h80, 8'h01};
  ppcr_byte_t      rsts  [7] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h00, 8'h00, 8'h00};
  // all single-bit controls except mixer_pass_ff in one word so one compare covers those fields
  wire logic [15:0] outs = {3'h0, conv_enable, conv_mute, phones_enable, phones_mute,
                            phones_drive, mixer_enable, pad_low_range};

  ppcr_regs #(.ZC_TIMEOUT_CYCLES(ZC)) ppcr_regs_inst (.clk, .rst_n, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wdata, .reg_rdata_ff, .conv_gain_target, .phones_gain_target,
    .gain_ramp_tick, .phones_zero_det, .mixer_select, .conv_enable, .conv_mute, .conv_gain_ff,
    .phones_enable, .phones_mute, .phones_drive, .phones_gain_ff, .mixer_enable,
    .mixer_pass_ff, .pad_low_range);

  always #2 clk = ~clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input ppcr_byte_t a, input ppcr_byte_t d);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input ppcr_byte_t a, input ppcr_byte_t exp);
    @(negedge clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd_en = 1'b0;
    chk("rdata", {8'h00, exp}, {8'h00, reg_rdata_ff});
  endtask

  // bit 2 ramp tick, bits 1:0 zero-cross strobes
  task automatic pulse(input logic [2:0] p);
    @(negedge clk);
    {gain_ramp_tick, phones_zero_det} = p;
    @(negedge clk);
    {gain_ramp_tick, phones_zero_det} = 3'b000;
    repeat (2) @(negedge clk);
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #8000;
    mismatches++;
    summarize();
  end

  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++) rd(addrs[i], rsts[i]);
    chk("outs", 16'h0660, outs);
    for (int i = 0; i < 7; i++) wr(addrs[i], 8'hff);
    wr(8'h6d, 8'hff);
    chk("outs", 16'h1fff, outs);
    for (int i = 0; i < 7; i++) rd(addrs[i], masks[i]);
    rd(8'h6d, 8'h00);
    mixer_select = 2'b01;
    repeat (2) @(negedge clk);
    chk("pass", 16'h0001, {14'h0, mixer_pass_ff});
    mixer_select = 2'b10;
    repeat (2) @(negedge clk);
    chk("pass", 16'h0002, {14'h0, mixer_pass_ff});
    for (int i = 0; i < 7; i++) wr(addrs[i], 8'h00);
    chk("outs", 16'h0000, outs);
    chk("pass", 16'h0000, {14'h0, mixer_pass_ff});
    phones_gain_target[0] = 6'h05;
    conv_gain_target[0] = 8'h20;
    phones_gain_target[1] = 6'h2a;
    conv_gain_target[1] = 8'h11;
    repeat (2) @(negedge clk);
    chk("phones gain", 16'h0005, {10'h0, phones_gain_ff[0]});
    chk("conv gain", 16'h0020, {8'h0, conv_gain_ff[0]});
    chk("phones right gain", 16'h002a, {10'h0, phones_gain_ff[1]});
    chk("conv right gain", 16'h0011, {8'h0, conv_gain_ff[1]});
    wr(8'h6b, 8'h10);
    wr(8'h69, 8'h20);
    phones_gain_target[0] = 6'h09;
    conv_gain_target[0] = 8'h22;
    repeat (4) @(negedge clk);
    chk("phones gain", 16'h0005, {10'h0, phones_gain_ff[0]});
    pulse(3'b101);
    chk("phones gain", 16'h0009, {10'h0, phones_gain_ff[0]});
    chk("conv gain", 16'h0021, {8'h0, conv_gain_ff[0]});
    phones_gain_target[0] = 6'h0c;
    repeat (ZC / 2) @(negedge clk);
    chk("phones gain", 16'h0009, {10'h0, phones_gain_ff[0]});
    repeat (ZC + 4) @(negedge clk);
    chk("phones gain", 16'h000c, {10'h0, phones_gain_ff[0]});
    wr(8'h6b, 8'h30);
    phones_gain_target[0] = 6'h0f;
    pulse(3'b001);
    chk("phones gain", 16'h000c, {10'h0, phones_gain_ff[0]});
    pulse(3'b100);
    chk("phones gain", 16'h000d, {10'h0, phones_gain_ff[0]});
    wr(8'h6b, 8'h04);
    repeat (2) @(negedge clk);
    chk("phones gain", 16'h0000, {10'h0, phones_gain_ff[0]});
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(8'h6b, 8'h40);
    summarize();
  end
endmodule
